// [design/alsee_encoder.v]
// application-layer status error encoder top level
`timescale 1ns/1ps
`include "alsee_regs.vh"
module alsee_encoder #(
  parameter WDT_WIDTH = 24,
  parameter SYNC_FIRST_CYC =
    `ALSEE_SYNC_FIRST_US * `ALSEE_CLK_MHZ,
  parameter SYNC_GAP_CYC = `ALSEE_SYNC_GAP_US * `ALSEE_CLK_MHZ
) (
  // clock and reset
  input  wire                 mclk,
  input  wire                 resetn,
  // state change request from the master
  input  wire                 stateReq,
  input  wire [3:0]           stateReqCode,
  output wire [3:0]           alState,
  // nonvolatile and identity checks
  input  wire                 nvCheckDone,
  input  wire                 nvCorrupt,
  input  wire                 idCheckDone,
  input  wire                 idFail,
  // configuration writes from the master
  input  wire                 mbxCfgWrite,
  input  wire                 mbxCfgBad,
  input  wire                 rxPdCfgWrite,
  input  wire                 rxPdCfgBad,
  input  wire                 txPdCfgWrite,
  input  wire                 txPdCfgBad,
  input  wire                 wdtCfgWrite,
  input  wire [WDT_WIDTH-1:0] wdtCfgValue,
  input  wire                 txMapWrite,
  input  wire                 txMapBad,
  input  wire                 rxMapWrite,
  input  wire                 rxMapBad,
  // cyclic traffic and clock sync
  input  wire                 pdFrame,
  input  wire                 dcMode,
  input  wire                 syncPin,
  // status towards the master
  output reg  [15:0]          statusCode,
  output reg                  errorFlag,
  input  wire                 errorAck,
  output reg                  mbxReject,
  // diagnosis history
  output reg                  histWrite,
  output reg  [15:0]          histCode
);
  reg [3:0]           state;
  reg [WDT_WIDTH-1:0] wdtLimit;
  reg                 wdtValid;
  reg                 syncMeta;
  reg                 syncSync;
  reg                 syncPrev;
  reg                 syncSeen;
  reg                 bootErr;
  reg [15:0]          next_code;
  reg                 next_log;
  reg                 next_err;
  reg                 reqKnown;
  reg                 reqLegal;
  wire                syncEdge;
  wire                pdExpired;
  wire                firstExpired;
  wire                gapExpired;

  assign alState  = state;
  assign syncEdge = syncSync & ~syncPrev;

  // sync pin into mclk domain
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncMeta <= 1'b0;
      syncSync <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      syncMeta <= syncPin;
      syncSync <= syncMeta;
      syncPrev <= syncSync;
    end
  end

  // request decode
  always @* begin
    reqKnown = 1'b0;
    reqLegal = 1'b0;
    case (stateReqCode)
      `ALSEE_ST_INIT: begin
        reqKnown = 1'b1;
        reqLegal = 1'b1;
      end
      `ALSEE_ST_PREOP: begin
        reqKnown = 1'b1;
        reqLegal = (state != `ALSEE_ST_BOOT);
      end
      `ALSEE_ST_BOOT: begin
        reqKnown = 1'b1;
        reqLegal = (state == `ALSEE_ST_INIT) ||
                   (state == `ALSEE_ST_BOOT);
      end
      `ALSEE_ST_SAFEOP: begin
        reqKnown = 1'b1;
        reqLegal = (state == `ALSEE_ST_PREOP) ||
                   (state == `ALSEE_ST_SAFEOP) ||
                   (state == `ALSEE_ST_OP);
      end
      `ALSEE_ST_OP: begin
        reqKnown = 1'b1;
        reqLegal = (state == `ALSEE_ST_SAFEOP) ||
                   (state == `ALSEE_ST_OP);
      end
      default: begin
        reqKnown = 1'b0;
        reqLegal = 1'b0;
      end
    endcase
  end

  // watchdogs
  alsee_pulse_watch #(.WIDTH(WDT_WIDTH)) uPdWdt (
    .mclk    (mclk),
    .resetn  (resetn),
    .arm     (wdtValid && state == `ALSEE_ST_OP),
    .seen    (pdFrame),
    .limit   (wdtLimit),
    .expired (pdExpired)
  );

  alsee_pulse_watch #(.WIDTH(24)) uSyncFirst (
    .mclk    (mclk),
    .resetn  (resetn),
    .arm     (dcMode && !syncSeen && !errorFlag),
    .seen    (syncEdge),
    .limit   (SYNC_FIRST_CYC[23:0]),
    .expired (firstExpired)
  );

  alsee_pulse_watch #(.WIDTH(24)) uSyncGap (
    .mclk    (mclk),
    .resetn  (resetn),
    .arm     (dcMode && syncSeen && state == `ALSEE_ST_OP),
    .seen    (syncEdge),
    .limit   (SYNC_GAP_CYC[23:0]),
    .expired (gapExpired)
  );

  // error selection, lowest priority first
  always @* begin
    next_code = `ALSEE_CODE_NONE;
    next_log  = 1'b0;
    next_err  = 1'b0;
    if (gapExpired) begin
      next_code = `ALSEE_CODE_SYNCLOST;
      next_err  = 1'b1;
    end
    if (firstExpired) begin
      next_code = `ALSEE_CODE_NOSYNC;
      next_err  = 1'b1;
    end
    if (pdExpired) begin
      next_code = `ALSEE_CODE_PDWDT;
      next_err  = 1'b1;
    end
    if (rxMapWrite && rxMapBad) begin
      next_code = `ALSEE_CODE_RXMAP;
      next_err  = 1'b1;
    end
    if (txMapWrite && txMapBad) begin
      next_code = `ALSEE_CODE_TXMAP;
      next_err  = 1'b1;
    end
    if (wdtCfgWrite && wdtCfgValue == {WDT_WIDTH{1'b0}}) begin
      next_code = `ALSEE_CODE_WDTSET;
      next_err  = 1'b1;
    end
    if (txPdCfgWrite && txPdCfgBad) begin
      next_code = `ALSEE_CODE_TXPDCFG;
      next_err  = 1'b1;
    end
    if (rxPdCfgWrite && rxPdCfgBad) begin
      next_code = `ALSEE_CODE_RXPDCFG;
      next_err  = 1'b1;
    end
    if (mbxCfgWrite && mbxCfgBad) begin
      next_code = `ALSEE_CODE_MBXSET;
      next_err  = 1'b1;
    end
    if (stateReq && reqKnown && !reqLegal) begin
      next_code = `ALSEE_CODE_BADTRANS;
      next_err  = 1'b1;
    end
    if (stateReq && !reqKnown) begin
      next_code = `ALSEE_CODE_UNKSTATE;
      next_err  = 1'b1;
    end
    if (idCheckDone && idFail) begin
      next_code = `ALSEE_CODE_IDCHECK;
      next_log  = 1'b1;
      next_err  = 1'b1;
    end
    if (nvCheckDone && nvCorrupt) begin
      next_code = `ALSEE_CODE_NVDATA;
      next_log  = 1'b1;
      next_err  = 1'b1;
    end
  end

  // state, config and status registers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state      <= `ALSEE_ST_INIT;
      wdtLimit   <= {WDT_WIDTH{1'b0}};
      wdtValid   <= 1'b0;
      syncSeen   <= 1'b0;
      bootErr    <= 1'b0;
      statusCode <= `ALSEE_CODE_NONE;
      errorFlag  <= 1'b0;
      mbxReject  <= 1'b0;
      histWrite  <= 1'b0;
      histCode   <= `ALSEE_CODE_NONE;
    end else begin
      histWrite <= next_log;
      if (next_log)
        histCode <= next_code;
      mbxReject <= mbxCfgWrite && mbxCfgBad;
      if (wdtCfgWrite && wdtCfgValue != {WDT_WIDTH{1'b0}}) begin
        wdtLimit <= wdtCfgValue;
        wdtValid <= 1'b1;
      end
      if (!dcMode)
        syncSeen <= 1'b0;
      else if (syncEdge)
        syncSeen <= 1'b1;
      if (next_log)
        bootErr <= 1'b1;
      // a new fault wins over the acknowledge
      if (next_err) begin
        statusCode <= next_code;
        errorFlag  <= 1'b1;
      end else if (errorAck) begin
        statusCode <= `ALSEE_CODE_NONE;
        errorFlag  <= 1'b0;
      end
      // process data and sync gap timeouts drop the machine to SAFEOP, logged faults to INIT when no such timeout comes in the same cycle
      if (next_err) begin
        if (pdExpired || gapExpired)
          state <= `ALSEE_ST_SAFEOP;
        else if (next_log)
          state <= `ALSEE_ST_INIT;
      end else if (stateReq && reqLegal && !bootErr &&
                   (!errorFlag ||
                    stateReqCode == `ALSEE_ST_INIT ||
                    stateReqCode == `ALSEE_ST_PREOP)) begin
        state <= stateReqCode;
      end
    end
  end
endmodule // alsee_encoder

// [design/alsee_pulse_watch.v]
// timeout watcher for a pulse or frame that must recur
`timescale 1ns/1ps
module alsee_pulse_watch #(
  parameter WIDTH = 20
) (
  // clock and reset
  input  wire             mclk,
  input  wire             resetn,
  // control
  input  wire             arm,
  input  wire             seen,
  input  wire [WIDTH-1:0] limit,
  // result
  output reg              expired
);
  reg [WIDTH-1:0] count;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count   <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (!arm || seen) begin
      count   <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (count >= limit) begin
      expired <= 1'b1;
    end else begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // alsee_pulse_watch

// [design/alsee_regs.vh]
// constants for the application-layer status error encoder
`ifndef ALSEE_REGS_VH
`define ALSEE_REGS_VH
`define ALSEE_CODE_NONE     16'h0000
`define ALSEE_CODE_NVDATA   16'h0001
`define ALSEE_CODE_BADTRANS 16'h0011
`define ALSEE_CODE_UNKSTATE 16'h0012
`define ALSEE_CODE_IDCHECK  16'h0014
`define ALSEE_CODE_MBXSET   16'h0016
`define ALSEE_CODE_PDWDT    16'h001b
`define ALSEE_CODE_RXPDCFG  16'h001d
`define ALSEE_CODE_TXPDCFG  16'h001e
`define ALSEE_CODE_WDTSET   16'h001f
`define ALSEE_CODE_TXMAP    16'h0024
`define ALSEE_CODE_RXMAP    16'h0025
`define ALSEE_CODE_SYNCLOST 16'h002c
`define ALSEE_CODE_NOSYNC   16'h002d
// state encodings of the application-layer machine
`define ALSEE_ST_INIT   4'h1
`define ALSEE_ST_PREOP  4'h2
`define ALSEE_ST_BOOT   4'h3
`define ALSEE_ST_SAFEOP 4'h4
`define ALSEE_ST_OP     4'h8
// sync pulse timeouts
`define ALSEE_SYNC_FIRST_US 1000
`define ALSEE_SYNC_GAP_US   100
`define ALSEE_CLK_MHZ       100
`endif

// [tb/alsee_master_model.sv]
// far-side master model: cyclic frames and sync pulses
`timescale 1ns/1ps
module alsee_master_model (
  // clock and reset
  input  wire mclk,
  input  wire resetn,
  // control from the bench
  input  wire frameEn,
  input  wire syncEn,
  // towards the slave
  output reg  pdFrame,
  output reg  syncPin
);
  reg [1:0] tick;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick    <= 2'h0;
      pdFrame <= 1'b0;
      syncPin <= 1'b0;
    end else begin
      tick    <= tick + 2'h1;
      // frame and sync rise every 4 cycles, pin low when idle
      pdFrame <= frameEn && tick == 2'h0;
      syncPin <= syncEn && tick[1];
    end
  end
endmodule // alsee_master_model

// [tb/alsee_props.sv]
// assertion checker for the status error encoder
`timescale 1ns/1ps
module alsee_props #(parameter WDT_WIDTH = 24) (
  // clock and reset
  input wire mclk, resetn,
  // events from the master
  input wire stateReq, nvCheckDone, nvCorrupt, idCheckDone, idFail,
  input wire mbxCfgWrite, mbxCfgBad, rxPdCfgWrite, rxPdCfgBad,
  input wire txPdCfgWrite, txPdCfgBad, wdtCfgWrite, errorAck, dcMode,
  input wire txMapWrite, txMapBad, rxMapWrite, rxMapBad,
  input wire [3:0] stateReqCode, alState,
  input wire [WDT_WIDTH-1:0] wdtCfgValue,
  // status outputs
  input wire errorFlag, mbxReject, histWrite,
  input wire [15:0] statusCode, histCode
);
  wire nvF = nvCheckDone & nvCorrupt;
  wire idF = idCheckDone & idFail;
  wire known = stateReqCode == 4'h1 || stateReqCode == 4'h2 ||
    stateReqCode == 4'h3 || stateReqCode == 4'h4 || stateReqCode == 4'h8;
  wire hi = nvF | idF | stateReq | (mbxCfgWrite & mbxCfgBad);
  wire rxF = rxPdCfgWrite & rxPdCfgBad;
  wire txF = txPdCfgWrite & txPdCfgBad;
  wire anyF = hi | rxF | txF | wdtCfgWrite | (txMapWrite & txMapBad) |
    (rxMapWrite & rxMapBad);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_nv_logged: assert property (
    nvF |=> statusCode == 16'h0001 && histWrite && histCode == 16'h0001)
    else $error("nv fault not reported");
  a_id_logged: assert property (
    idF && !nvF |=> statusCode == 16'h0014 && histCode == 16'h0014)
    else $error("identity fault not reported");
  a_unknown_state: assert property (
    stateReq && !known && !nvF && !idF |=> statusCode == 16'h0012)
    else $error("unknown state code missing");
  a_illegal_op: assert property (
    stateReq && stateReqCode == 4'h8 && alState == 4'h1 && !nvF && !idF
    |=> statusCode == 16'h0011 && alState == 4'h1)
    else $error("illegal transition code missing");
  a_mbx_reject: assert property (
    mbxCfgWrite && mbxCfgBad |=> mbxReject)
    else $error("mailbox setting not rejected");
  a_rx_cfg: assert property (
    rxF && !hi |=> statusCode == 16'h001d)
    else $error("receive config code missing");
  a_wdt_zero: assert property (
    wdtCfgWrite && wdtCfgValue == 0 && !hi && !rxF && !txF
    |=> statusCode == 16'h001f)
    else $error("watchdog setting code missing");
  a_hist_cause: assert property (
    histWrite |-> ($past(nvF) || $past(idF)) &&
    (histCode == 16'h0001 || histCode == 16'h0014))
    else $error("history written for unlogged fault");
  a_flag_holds: assert property (
    errorFlag && !errorAck |=> errorFlag)
    else $error("error flag dropped without ack");
  a_ack_clears: assert property (
    errorFlag && errorAck && !anyF && !dcMode && alState != 4'h8 &&
    !$past(dcMode) && $past(alState) != 4'h8
    |=> !errorFlag && statusCode == 16'h0000)
    else $error("ack did not clear status");
endmodule // alsee_props
bind alsee_encoder alsee_props #(.WDT_WIDTH(WDT_WIDTH)) u_props (
  .mclk, .resetn, .stateReq, .nvCheckDone, .nvCorrupt, .idCheckDone,
  .idFail, .mbxCfgWrite, .mbxCfgBad, .rxPdCfgWrite, .rxPdCfgBad,
  .txPdCfgWrite, .txPdCfgBad, .wdtCfgWrite, .errorAck, .dcMode,
  .txMapWrite, .txMapBad, .rxMapWrite, .rxMapBad, .stateReqCode,
  .alState, .wdtCfgValue, .errorFlag, .mbxReject, .histWrite,
  .statusCode, .histCode);

// [tb/testbench.sv]
// self-checking bench for the status error encoder
`timescale 1ns/1ps
module testbench;
  reg         mclk = 1'b0, resetn = 1'b0, stateReq = 1'b0;
  reg         errorAck = 1'b0, dcMode = 1'b0, frameEn = 1'b0, syncEn = 1'b0;
  reg  [3:0]  stateReqCode = 4'h1;
  reg  [7:0]  wr = 8'h00, bad = 8'h00;
  reg  [23:0] wdtVal = 24'h000001;
  wire        pdFrame, syncPin, errorFlag, mbxReject, histWrite;
  wire [3:0]  alState;
  wire [15:0] statusCode, histCode;
  integer     fails = 0, comparisons = 0, cyc = 0, lim, k, b, i;
  integer     expCode = 0;
  integer     histQ [$];
  reg  [15:0] codes [0:7] = '{16'h0016, 16'h001d, 16'h001e, 16'h0024,
    16'h0025, 16'h0001, 16'h0014, 16'h001f};
  alsee_encoder #(.SYNC_FIRST_CYC(20), .SYNC_GAP_CYC(10)) uut (
    .mclk(mclk), .resetn(resetn), .stateReq(stateReq),
    .stateReqCode(stateReqCode), .alState(alState),
    .nvCheckDone(wr[5]), .nvCorrupt(bad[5]), .idCheckDone(wr[6]),
    .idFail(bad[6]), .mbxCfgWrite(wr[0]), .mbxCfgBad(bad[0]),
    .rxPdCfgWrite(wr[1]), .rxPdCfgBad(bad[1]), .txPdCfgWrite(wr[2]),
    .txPdCfgBad(bad[2]), .wdtCfgWrite(wr[7]), .wdtCfgValue(wdtVal),
    .txMapWrite(wr[3]), .txMapBad(bad[3]), .rxMapWrite(wr[4]),
    .rxMapBad(bad[4]), .pdFrame(pdFrame), .dcMode(dcMode),
    .syncPin(syncPin), .statusCode(statusCode), .errorFlag(errorFlag),
    .errorAck(errorAck), .mbxReject(mbxReject), .histWrite(histWrite),
    .histCode(histCode));
  alsee_master_model master (.mclk(mclk), .resetn(resetn),
    .frameEn(frameEn), .syncEn(syncEn), .pdFrame(pdFrame),
    .syncPin(syncPin));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  task chk(input string n, input [15:0] e, input [15:0] s);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task status(input [3:0] st);
    begin
      chk("statusCode", expCode[15:0], statusCode);
      chk("errorFlag", {15'h0, expCode != 0}, {15'h0, errorFlag});
      if (st != 4'h0) chk("alState", {12'h0, st}, {12'h0, alState});
    end
  endtask
  task fire(input integer n, input integer bb);
    begin
      @(posedge mclk);
      wr <= 8'h01 << n;
      bad <= {7'h0, bb[0]} << n;
      wdtVal <= bb ? 24'h0 : lim[23:0];
      @(posedge mclk);
      wr <= 8'h00;
      bad <= 8'h00;
      #1;
      if (bb) expCode = codes[n];
      if (bb && (n == 5 || n == 6)) histQ.push_back(codes[n]);
      status(4'h0);
      chk("mbxReject", {15'h0, n == 0 && bb}, {15'h0, mbxReject});
      chk("histWrite", {15'h0, histQ.size() > 0}, {15'h0, histWrite});
      if (histWrite === 1'b1) chk("histCode", histQ.pop_front(), histCode);
    end
  endtask
  task ack;
    begin
      @(posedge mclk);
      errorAck <= 1'b1;
      @(posedge mclk);
      errorAck <= 1'b0;
      #1;
      expCode = 0;
      status(4'h0);
    end
  endtask
  task req(input [3:0] c, input [15:0] e, input [3:0] st);
    begin
      @(posedge mclk);
      stateReq <= 1'b1;
      stateReqCode <= c;
      @(posedge mclk);
      stateReq <= 1'b0;
      #1;
      expCode = e;
      status(st);
    end
  endtask
  task waitErr(input integer n, input [15:0] e, input [3:0] st);
    begin
      for (i = 0; i < n && errorFlag !== 1'b1; i = i + 1) begin
        @(posedge mclk);
        #1;
      end
      #1;
      expCode = e;
      status(st);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    k = $urandom(12);
    lim = 6 + $urandom % 8;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    status(4'h1);
    for (k = 0; k < 10; k = k + 1) begin
      b = (k < 5) ? 1 : $urandom % 2;
      fire(k % 5, b);
      if (b) ack;
    end
    $display("test config faults done");
    req(4'h8, 16'h0011, 4'h1);
    ack;
    req(4'h5, 16'h0012, 4'h1);
    ack;
    req(4'h2, 16'h0000, 4'h2);
    req(4'h3, 16'h0011, 4'h2);
    ack;
    fire(7, 1);
    ack;
    fire(7, 0);
    frameEn <= 1'b1;
    req(4'h4, 16'h0000, 4'h4);
    req(4'h8, 16'h0000, 4'h8);
    waitErr(40, 16'h0000, 4'h8);
    frameEn <= 1'b0;
    waitErr(lim + 6, 16'h001b, 4'h4);
    ack;
    $display("test states and watchdog done");
    dcMode <= 1'b1;
    waitErr(30, 16'h002d, 4'h0);
    dcMode <= 1'b0;
    ack;
    syncEn <= 1'b1;
    frameEn <= 1'b1;
    dcMode <= 1'b1;
    req(4'h8, 16'h0000, 4'h8);
    waitErr(30, 16'h0000, 4'h8);
    syncEn <= 1'b0;
    waitErr(30, 16'h002c, 4'h4);
    dcMode <= 1'b0;
    frameEn <= 1'b0;
    ack;
    $display("test sync done");
    fire(5, 1);
    ack;
    fire(6, 1);
    ack;
    $display("test logged faults done");
    give_verdict;
  end
endmodule // testbench
